/* verilog/sysclk_consts.vh */
// Register offsets, field positions, reset values for the clock and power control block
`ifndef SYSCLK_CONSTS_VH
`define SYSCLK_CONSTS_VH
`define OFF_WORK_MODE      12'h00c
`define OFF_POWER_DOMAIN   12'h010
`define OFF_CLKSEL0        12'h014
`define OFF_CLKSEL1        12'h018
`define OFF_GATE0          12'h01c
`define OFF_GATE1          12'h020
`define OFF_GATE2          12'h024
`define RST_WORK_MODE      8'h00
`define RST_POWER_CTRL     5'h00
`define RST_CLKSEL0        32'h06300734
`define RST_CLKSEL1        31'h0003000c
`define RST_GATE           32'h00000000
`define WM_IRQ_CLR         8
`define WM_WAKE_POL        7
`define WM_RTC_WAKE_DIS    6
`define WM_PIN_WAKE_DIS    5
`define WM_STOP_EN         4
`define PD_PIN_SWITCH_EN   4
`define GATE1_MASK         32'h000fffff
`define GATE2_MASK         32'h000001ff
`define MODE_SLOW          2'h0
`define MODE_NORMAL        2'h1
`define MODE_DEEP_SLOW     2'h2
`endif

/* verilog/clock_divider.v */
// Glitch-free integer clock divider, new ratio loaded only at a period boundary
`timescale 1ns/1ps
module clock_divider
(
   clk_sys,
   rst_b,
   div_value,
   clk_en,
   div_out
);
   parameter W = 8;
   input              clk_sys;
   input              rst_b;
   input  [W-1:0]     div_value;
   input              clk_en;
   output             div_out;

   reg    [W-1:0]     count_reg;
   reg    [W-1:0]     ratio_reg;
   reg                out_reg;
   wire   [W-1:0]     count_next;
   // One bit wider so an all-ones ratio does not wrap the midpoint to zero
   wire   [W:0]       half_point;

   assign count_next = (count_reg >= ratio_reg) ? {W{1'b0}} : count_reg + {{(W-1){1'b0}}, 1'b1};
   assign half_point = ({1'b0, ratio_reg} + {{W{1'b0}}, 1'b1}) >> 1;
   assign div_out    = out_reg;

   // Ratio latched only at wrap so a change never cuts a period short
   always @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         count_reg <= {W{1'b0}};
         ratio_reg <= {W{1'b0}};
         out_reg   <= 1'b0;
      end
      else
      begin
         count_reg <= count_next;
         if (count_next == {W{1'b0}})
         begin
            ratio_reg <= div_value;
         end
         // Gate applied at period start only, no runt pulse
         if (count_next == {W{1'b0}})
         begin
            out_reg <= clk_en;
         end
         else if ({1'b0, count_next} == half_point)
         begin
            out_reg <= 1'b0;
         end
      end
   end
endmodule

/* verilog/system_clock_power_control.v */
// APB register bank and control outputs for system clocks, work modes and power domains
`timescale 1ns/1ps
`include "sysclk_consts.vh"
// How it works
// - Writing one to work-mode bit 8 clears the pending interrupt.
// - Work-mode bit 7 picks wakeup pin polarity: zero high, one low.
// - Work-mode bit 6 set blocks alarm and interrupt wakeup from stop.
// - Work-mode bit 5 set blocks the external pin wakeup from stop.
// - Work-mode bit 4 set enters stop mode.
// - CPU mode bits 3:2: 00/11 slow, 01 normal, 10 deep slow.
// - DSP mode bits 1:0 decode the same way.
// - Power bits 8:5 read one for each domain that is off.
// - Power bit 4 lets an external pin switch CPU domain power.
// - Power bits 3:0 power down domains four to one when set.
// - Card clocks are bus clock over field plus one, default four.
// - Sensor clock select: 00 24MHz, 01 27MHz, 10 48MHz.
// - 48MHz clock is core clock over field plus one.
// - USB PHY clock select: 00 24MHz, 01 12MHz, 10 48MHz.
// - Display clock from selected PLL divided, or external 27MHz.
// - Bus-to-peripheral and core-to-bus ratio fields drive clock ratios.
// - Shared memory clocks from demodulator or bus clock per bit.
// - Demodulator clock from selected PLL divided, or external; converter options.
// - Low-speed converter clock is peripheral clock over field plus one.
// - Codec clock is codec PLL divided, or 12MHz oscillator if bit 2.
// - Codec PLL mode: 00 oscillator, 01 PLL, 10 deep slow.
// - Each gate bit set stops its clock; all reset to zero.
// - In stop mode a wakeup pin edge to its active level resumes operation.
module system_clock_power_control
(
   clk_sys,
   rst_b,
   psel,
   penable,
   pwrite,
   paddr,
   pwdata,
   prdata,
   pready,
   pslverr,
   irq_event,
   wakeup_pin,
   rtc_alarm,
   domain_off_status,
   irq_pending,
   stop_active,
   cpu_mode,
   dsp_mode,
   domain_power_down,
   cpu_pin_switch_en,
   card0_clock_divider,
   card1_clock_divider,
   sensor_clock_select,
   fortyeight_clock_divider,
   usb_phy_clock_select,
   display_pll_select,
   display_divider,
   display_external_select,
   bus_to_periph_ratio,
   core_to_bus_ratio,
   shared_mem_clock_select,
   hs_adc_invert,
   tuner_clock_route,
   demod_external_select,
   demod_pll_select,
   demod_divider,
   low_speed_adc_divider,
   codec_divider,
   codec_oscillator_select,
   codec_pll_mode,
   clock_gate_disable,
   card0_clock,
   card1_clock
);
   input              clk_sys;
   input              rst_b;
   input              psel;
   input              penable;
   input              pwrite;
   input  [11:0]      paddr;
   input  [31:0]      pwdata;
   output [31:0]      prdata;
   output             pready;
   output             pslverr;
   input              irq_event;
   input              wakeup_pin;
   input              rtc_alarm;
   input  [3:0]       domain_off_status;
   output             irq_pending;
   output             stop_active;
   output [1:0]       cpu_mode;
   output [1:0]       dsp_mode;
   output [3:0]       domain_power_down;
   output             cpu_pin_switch_en;
   output [2:0]       card0_clock_divider;
   output [2:0]       card1_clock_divider;
   output [1:0]       sensor_clock_select;
   output [2:0]       fortyeight_clock_divider;
   output [1:0]       usb_phy_clock_select;
   output [1:0]       display_pll_select;
   output [7:0]       display_divider;
   output             display_external_select;
   output [1:0]       bus_to_periph_ratio;
   output [1:0]       core_to_bus_ratio;
   output [1:0]       shared_mem_clock_select;
   output             hs_adc_invert;
   output             tuner_clock_route;
   output             demod_external_select;
   output [1:0]       demod_pll_select;
   output [7:0]       demod_divider;
   output [7:0]       low_speed_adc_divider;
   output [4:0]       codec_divider;
   output             codec_oscillator_select;
   output [1:0]       codec_pll_mode;
   output [95:0]      clock_gate_disable;
   output             card0_clock;
   output             card1_clock;

   reg    [7:0]       work_mode_reg;
   reg                irq_pending_reg;
   reg                stop_reg;
   reg    [1:0]       cpu_mode_reg;
   reg    [1:0]       dsp_mode_reg;
   reg    [4:0]       power_ctrl_reg;
   reg    [3:0]       domain_status_reg;
   reg    [31:0]      clksel0_reg;
   reg    [30:0]      clksel1_reg;
   reg    [31:0]      gate_mem [0:2];
   integer            gi;
   wire   [6:0]       hit;
   reg    [31:0]      prdata_reg;
   reg                wake_prev_reg;
   reg    [31:0]      rd_next;
   wire               wr_en;
   wire               rd_en;
   wire               wake_level;
   wire               pin_wake;
   wire               rtc_wake;

   assign wr_en = psel & penable & pwrite;
   assign rd_en = psel & ~penable & ~pwrite;

   // Decoded 2-bit work mode: 00 and 11 both collapse to slow
   function [1:0] decode_mode;
      input [1:0] code;
      begin
         if (code == 2'h1)
            decode_mode = `MODE_NORMAL;
         else if (code == 2'h2)
            decode_mode = `MODE_DEEP_SLOW;
         else
            decode_mode = `MODE_SLOW;
      end
   endfunction

   // One-hot register select, shared by the write and read paths
   function [6:0] reg_hit;
      input [11:0] addr;
      begin
         reg_hit = 7'h00;
         if (addr == `OFF_WORK_MODE)
            reg_hit = 7'h01;
         else if (addr == `OFF_POWER_DOMAIN)
            reg_hit = 7'h02;
         else if (addr == `OFF_CLKSEL0)
            reg_hit = 7'h04;
         else if (addr == `OFF_CLKSEL1)
            reg_hit = 7'h08;
         else if (addr == `OFF_GATE0)
            reg_hit = 7'h10;
         else if (addr == `OFF_GATE1)
            reg_hit = 7'h20;
         else if (addr == `OFF_GATE2)
            reg_hit = 7'h40;
      end
   endfunction

   // Writable bits of each gate bank; reserved bits always read zero
   function [31:0] gate_mask;
      input integer bank;
      begin
         if (bank == 1)
            gate_mask = `GATE1_MASK;
         else if (bank == 2)
            gate_mask = `GATE2_MASK;
         else
            gate_mask = 32'hffffffff;
      end
   endfunction

   assign hit = reg_hit(paddr);

   // Polarity bit inverts the pin before edge detection
   assign wake_level = wakeup_pin ^ work_mode_reg[`WM_WAKE_POL];
   assign pin_wake   = wake_level & ~wake_prev_reg & ~work_mode_reg[`WM_PIN_WAKE_DIS];
   assign rtc_wake   = (rtc_alarm | irq_event) & ~work_mode_reg[`WM_RTC_WAKE_DIS];

   always @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         work_mode_reg     <= `RST_WORK_MODE;
         irq_pending_reg   <= 1'b0;
         stop_reg          <= 1'b0;
         cpu_mode_reg      <= `MODE_SLOW;
         dsp_mode_reg      <= `MODE_SLOW;
         power_ctrl_reg    <= `RST_POWER_CTRL;
         domain_status_reg <= 4'h0;
         clksel0_reg       <= `RST_CLKSEL0;
         clksel1_reg       <= `RST_CLKSEL1;
         prdata_reg        <= 32'h00000000;
         wake_prev_reg     <= 1'b0;
      end
      else
      begin
         wake_prev_reg     <= wake_level;
         domain_status_reg <= domain_off_status;
         cpu_mode_reg      <= decode_mode(work_mode_reg[3:2]);
         dsp_mode_reg      <= decode_mode(work_mode_reg[1:0]);
         // New event beats a simultaneous clear
         if (irq_event)
            irq_pending_reg <= 1'b1;
         else if (wr_en && hit[0] && pwdata[`WM_IRQ_CLR])
            irq_pending_reg <= 1'b0;
         // Stop entered by write of bit 4, left on any enabled wakeup
         if (pin_wake || rtc_wake)
            stop_reg <= 1'b0;
         else if (wr_en && hit[0])
            stop_reg <= pwdata[`WM_STOP_EN];
         if (wr_en)
         begin
            if (hit[0])
            begin
               work_mode_reg <= pwdata[7:0];
               if (!(pin_wake || rtc_wake))
                  work_mode_reg[`WM_STOP_EN] <= pwdata[`WM_STOP_EN];
               else
                  work_mode_reg[`WM_STOP_EN] <= 1'b0;
            end
            else if (hit[1])
               power_ctrl_reg <= pwdata[4:0];
            else if (hit[2])
               clksel0_reg <= {4'h0, pwdata[27:0]};
            else if (hit[3])
               clksel1_reg <= pwdata[30:0];
         end
         else if (pin_wake || rtc_wake)
            work_mode_reg[`WM_STOP_EN] <= 1'b0;
         if (rd_en)
            prdata_reg <= rd_next;
      end
   end

   // Gate banks share one write path, indexed by bank number
   always @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         for (gi = 0; gi < 3; gi = gi + 1)
            gate_mem[gi] <= `RST_GATE;
      end
      else
      begin
         for (gi = 0; gi < 3; gi = gi + 1)
         begin
            if (wr_en && hit[gi + 4])
               gate_mem[gi] <= pwdata & gate_mask(gi);
         end
      end
   end

   always @*
   begin
      rd_next = 32'h00000000;
      if (hit[0])
         rd_next = {23'h000000, irq_pending_reg, work_mode_reg[7:5], stop_reg, work_mode_reg[3:0]};
      else if (hit[1])
         rd_next = {23'h000000, domain_status_reg, power_ctrl_reg};
      else if (hit[2])
         rd_next = clksel0_reg;
      else if (hit[3])
         rd_next = {1'b0, clksel1_reg};
      else if (hit[4])
         rd_next = gate_mem[0];
      else if (hit[5])
         rd_next = gate_mem[1];
      else if (hit[6])
         rd_next = gate_mem[2];
   end

   // Card clocks, one divider each; gate bits 31 and 14 stop them
   clock_divider #(.W(3)) u_card1_div
   (
      .clk_sys   (clk_sys),
      .rst_b     (rst_b),
      .div_value (clksel0_reg[27:25]),
      .clk_en    (~gate_mem[0][31]),
      .div_out   (card1_clock)
   );

   clock_divider #(.W(3)) u_card0_div
   (
      .clk_sys   (clk_sys),
      .rst_b     (rst_b),
      .div_value (clksel0_reg[6:4]),
      .clk_en    (~gate_mem[0][14]),
      .div_out   (card0_clock)
   );

   assign prdata                   = prdata_reg;
   assign pready                   = 1'b1;
   assign pslverr                  = 1'b0;
   assign irq_pending              = irq_pending_reg;
   assign stop_active              = stop_reg;
   assign cpu_mode                 = cpu_mode_reg;
   assign dsp_mode                 = dsp_mode_reg;
   assign domain_power_down        = power_ctrl_reg[3:0];
   assign cpu_pin_switch_en        = power_ctrl_reg[`PD_PIN_SWITCH_EN];
   assign card1_clock_divider      = clksel0_reg[27:25];
   assign sensor_clock_select      = clksel0_reg[24:23];
   assign fortyeight_clock_divider = clksel0_reg[22:20];
   assign usb_phy_clock_select     = clksel0_reg[19:18];
   assign display_pll_select       = clksel0_reg[17:16];
   assign display_divider          = clksel0_reg[15:8];
   assign display_external_select  = clksel0_reg[7];
   assign card0_clock_divider      = clksel0_reg[6:4];
   assign bus_to_periph_ratio      = clksel0_reg[3:2];
   assign core_to_bus_ratio        = clksel0_reg[1:0];
   assign shared_mem_clock_select  = clksel1_reg[30:29];
   assign hs_adc_invert            = clksel1_reg[28];
   assign tuner_clock_route        = clksel1_reg[27];
   assign demod_external_select    = clksel1_reg[26];
   assign demod_pll_select         = clksel1_reg[25:24];
   assign demod_divider            = clksel1_reg[23:16];
   assign low_speed_adc_divider    = clksel1_reg[15:8];
   assign codec_divider            = clksel1_reg[7:3];
   assign codec_oscillator_select  = clksel1_reg[2];
   assign codec_pll_mode           = clksel1_reg[1:0];
   assign clock_gate_disable       = {gate_mem[2], gate_mem[1], gate_mem[0]};
endmodule

/* sim/system_clock_power_control_asserts.sv */
// Port-level assertions for the clock and power control block
`timescale 1ns/1ps
module system_clock_power_control_asserts
(
   input logic        clk_sys,
   input logic        rst_b,
   input logic        psel,
   input logic        penable,
   input logic        pwrite,
   input logic [11:0] paddr,
   input logic [31:0] pwdata,
   input logic [31:0] prdata,
   input logic        irq_event,
   input logic        wakeup_pin,
   input logic        rtc_alarm,
   input logic [3:0]  domain_off_status,
   input logic        irq_pending,
   input logic        stop_active,
   input logic [1:0]  cpu_mode,
   input logic [1:0]  dsp_mode,
   input logic [3:0]  domain_power_down,
   input logic        cpu_pin_switch_en,
   input logic [95:0] clock_gate_disable
);
   logic       wr;
   logic [7:0] wm_h;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);

   assign wr = psel && penable && pwrite;

   // Shadow of the stored work-mode bits, needed to judge wakeup
   always @(posedge clk_sys or negedge rst_b)
      if (!rst_b)
         wm_h <= 8'h00;
      else if (wr && paddr == 12'h00c)
         wm_h <= pwdata[7:0];

   function automatic [1:0] dec(input [1:0] c);
      dec = (c == 2'h3) ? 2'h0 : c;
   endfunction

   AST_IRQ_SET: assert property (irq_event |=> irq_pending)
      else $error("pending flag not set");
   AST_IRQ_CLR: assert property (wr && paddr == 12'h00c && pwdata[8] && !irq_event |=> !irq_pending)
      else $error("pending flag not cleared");
   AST_STOP_SET: assert property (wr && paddr == 12'h00c && pwdata[6:4] == 3'h7 |=> stop_active)
      else $error("stop not entered");
   AST_PIN_BLOCK: assert property (stop_active && wm_h[6:5] == 2'h3 && !wr |=> stop_active)
      else $error("stop left while all wakeups blocked");
   AST_PIN_WAKE: assert property (stop_active && !wm_h[5] && !wr && $rose(wakeup_pin ^ wm_h[7])
      |-> ##[1:4] !stop_active)
      else $error("pin did not wake");
   AST_LEVEL_WAKE: assert property (stop_active && !wm_h[6] && (rtc_alarm || irq_event) && !wr
      |-> ##[1:3] !stop_active)
      else $error("alarm did not wake");
   AST_CPU_MODE: assert property (cpu_mode == dec($past(wm_h[3:2])))
      else $error("cpu mode decode wrong");
   AST_DSP_MODE: assert property (dsp_mode == dec($past(wm_h[1:0])))
      else $error("dsp mode decode wrong");
   AST_POWER: assert property (wr && paddr == 12'h010 |=> {cpu_pin_switch_en, domain_power_down} == $past(pwdata[4:0]))
      else $error("power control not taken");
   AST_GATE2: assert property (wr && paddr == 12'h024 |=> clock_gate_disable[95:64] == ($past(pwdata) & 32'h1ff))
      else $error("gate bank two wrong");
   AST_STATUS: assert property (psel && !penable && !pwrite && paddr == 12'h010
      |=> prdata[8:5] == $past(domain_off_status, 2) && prdata[31:9] == 23'h0)
      else $error("domain status read wrong");
endmodule

/* sim/system_clock_power_control_tb.sv */
// Self-checking bench for the clock and power control block
`timescale 1ns/1ps
module system_clock_power_control_tb;
   logic        clk_sys, rst_b, psel, penable, pwrite, pready, pslverr, irq_event, wakeup_pin, rtc_alarm;
   logic        irq_pending, stop_active, cpu_pin_switch_en, display_external_select, hs_adc_invert;
   logic        tuner_clock_route, demod_external_select, codec_oscillator_select, card0_clock, card1_clock;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, w;
   logic [3:0]  domain_off_status, domain_power_down;
   logic [1:0]  cpu_mode, dsp_mode, sensor_clock_select, usb_phy_clock_select, display_pll_select, codec_pll_mode;
   logic [1:0]  bus_to_periph_ratio, core_to_bus_ratio, shared_mem_clock_select, demod_pll_select;
   logic [2:0]  card0_clock_divider, card1_clock_divider, fortyeight_clock_divider;
   logic [7:0]  display_divider, demod_divider, low_speed_adc_divider;
   logic [4:0]  codec_divider;
   logic [95:0] clock_gate_disable;
   logic [31:0] m [0:10];
   int          err_total, total_checks, k, i;

   system_clock_power_control u_system_clock_power_control (.*);

   task chk(input [31:0] e, input [31:0] g);
   begin
      total_checks++;
      if (g !== e)
      begin
         err_total++;
         $display("wrong value at %0t: expected %h got %h", $time, e, g);
      end
   end
   endtask

   task print_verdict;
   begin
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   end
   endtask

   task xfer(input [11:0] a, input wt, input [31:0] d);
   begin
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= wt;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   end
   endtask

   function [31:0] msk(input int n);
      case (n)
         3: msk = 32'h000000ef;
         4: msk = 32'h0000001f;
         5: msk = 32'h0fffffff;
         6: msk = 32'h7fffffff;
         7: msk = 32'hffffffff;
         8: msk = 32'h000fffff;
         9: msk = 32'h000001ff;
         default: msk = 32'h0;
      endcase
   endfunction

   function [1:0] dec(input [1:0] c);
      dec = (c == 2'h3) ? 2'h0 : c;
   endfunction

   // Modes lag the register by a cycle, so look two falling edges on
   task fields;
   begin
      repeat (2) @(negedge clk_sys);
      chk(m[5], {4'h0, card1_clock_divider, sensor_clock_select, fortyeight_clock_divider,
         usb_phy_clock_select, display_pll_select, display_divider, display_external_select,
         card0_clock_divider, bus_to_periph_ratio, core_to_bus_ratio});
      chk(m[6], {1'b0, shared_mem_clock_select, hs_adc_invert, tuner_clock_route,
         demod_external_select, demod_pll_select, demod_divider, low_speed_adc_divider, codec_divider,
         codec_oscillator_select, codec_pll_mode});
      chk(m[4], {27'h0, cpu_pin_switch_en, domain_power_down});
      chk(m[7], clock_gate_disable[31:0]);
      chk(m[8], clock_gate_disable[63:32]);
      chk(m[9], clock_gate_disable[95:64]);
      chk({28'h0, dec(m[3][3:2]), dec(m[3][1:0])}, {28'h0, cpu_mode, dsp_mode});
      @(posedge clk_sys);
   end
   endtask

   task stop_try(input [8:0] v, input p, input r, input [31:0] e);
   begin
      wakeup_pin <= v[7];
      xfer(12'h00c, 1'b1, {23'h0, v});
      @(negedge clk_sys);
      chk(32'h1, {31'h0, stop_active});
      @(posedge clk_sys);
      wakeup_pin <= v[7] ^ p;
      rtc_alarm <= r;
      for (k = 0; k < 8 && stop_active; k++)
         @(negedge clk_sys);
      chk(e, {31'h0, stop_active});
      @(posedge clk_sys);
      rtc_alarm <= 1'b0;
   end
   endtask

   // Counts clock cycles between two rising edges of a card clock; zero if it stands still
   task per(input s, input [31:0] e);
      int n, r;
      logic c, p;
   begin
      r = 0;
      n = 0;
      p = 1'b1;
      repeat (40)
      begin
         @(negedge clk_sys);
         c = s ? card1_clock : card0_clock;
         if (c && !p)
         begin
            r++;
            if (r == 2)
               break;
            n = 0;
         end
         n++;
         p = c;
      end
      chk(e, (r == 2) ? 32'(n) : 32'h0);
   end
   endtask

   initial
   begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   initial
   begin
      repeat (20000) @(posedge clk_sys);
      err_total++;
      print_verdict;
   end

   initial
   begin
      {rst_b, psel, penable, pwrite, irq_event, wakeup_pin, rtc_alarm} = 7'h0;
      paddr = 12'h0;
      pwdata = 32'h0;
      domain_off_status = 4'h0;
      for (k = 0; k <= 10; k++)
         m[k] = 32'h0;
      m[5] = 32'h06300734;
      m[6] = 32'h0003000c;
      w = $urandom(32'h0116);
      repeat (5) @(posedge clk_sys);
      rst_b <= 1'b1;
      for (k = 0; k <= 10; k++)
      begin
         xfer(12'(4 * k), 1'b0, 32'h0);
         chk(m[k], rd);
      end
      fields;
      $display("test reset values done");
      for (i = 0; i < 3; i++)
      begin
         domain_off_status <= 4'($urandom);
         for (k = 0; k <= 10; k++)
         begin
            w = $urandom & 32'hfffffeef;
            xfer(12'(4 * k), 1'b1, w);
            m[k] = w & msk(k);
         end
         for (k = 0; k <= 10; k++)
         begin
            xfer(12'(4 * k), 1'b0, 32'h0);
            chk((k == 4) ? (m[4] | {23'h0, domain_off_status, 5'h0}) : m[k], rd);
         end
         fields;
      end
      $display("test random access done");
      for (i = 0; i < 4; i++)
      begin
         m[3] = 32'(3 * i + 3) & 32'hf;
         xfer(12'h00c, 1'b1, m[3]);
         fields;
      end
      $display("test work modes done");
      stop_try(9'h050, 1'b0, 1'b1, 32'h1);
      stop_try(9'h070, 1'b1, 1'b0, 32'h1);
      stop_try(9'h0d0, 1'b1, 1'b0, 32'h0);
      stop_try(9'h050, 1'b1, 1'b0, 32'h0);
      stop_try(9'h010, 1'b0, 1'b1, 32'h0);
      $display("test stop and wakeup done");
      irq_event <= 1'b1;
      @(posedge clk_sys);
      irq_event <= 1'b0;
      xfer(12'h00c, 1'b1, 32'h0);
      xfer(12'h00c, 1'b0, 32'h0);
      chk(32'h100, rd);
      xfer(12'h00c, 1'b1, 32'h100);
      xfer(12'h00c, 1'b0, 32'h0);
      chk(32'h0, rd);
      $display("test interrupt clear done");
      xfer(12'h01c, 1'b1, 32'h0);
      xfer(12'h014, 1'b1, 32'h06300724);
      per(1'b0, 32'h3);
      per(1'b1, 32'h4);
      xfer(12'h01c, 1'b1, 32'h00004000);
      per(1'b0, 32'h0);
      $display("test card clocks done");
      print_verdict;
   end
endmodule

bind system_clock_power_control system_clock_power_control_asserts u_asserts (.*);
